/* File: rtl/tlic_pkg.sv */
// constants of the two-level interrupt controller
// assumes 8-bit registers in the low byte of 32-bit Avalon-MM words
package tlic_pkg;
  // machine cycle and hardware call length
  localparam int TLIC_CLK_PER_MC = 4;
  localparam int TLIC_CALL_MC = 4;
  localparam int TLIC_NSRC = 12;
  localparam int TLIC_NFLAG = 15;
  // register byte offsets
  localparam logic [5:0] TLIC_OFS_TIMER_CTRL = 6'h00;
  localparam logic [5:0] TLIC_OFS_EXT_FLAG = 6'h04;
  localparam logic [5:0] TLIC_OFS_T2_MODE = 6'h08;
  localparam logic [5:0] TLIC_OFS_WDOG_CTRL = 6'h0C;
  localparam logic [5:0] TLIC_OFS_IRQ_EN = 6'h10;
  localparam logic [5:0] TLIC_OFS_EXT_EN = 6'h14;
  localparam logic [5:0] TLIC_OFS_PRIO = 6'h18;
  localparam logic [5:0] TLIC_OFS_EXT_PRIO = 6'h1C;
  localparam logic [5:0] TLIC_OFS_SER0_CTRL = 6'h20;
  localparam logic [5:0] TLIC_OFS_SER1_CTRL = 6'h24;
  localparam logic [5:0] TLIC_OFS_T2_FLAGS = 6'h28;
  localparam logic [5:0] TLIC_OFS_STATUS = 6'h2C;
  // field positions
  localparam int TLIC_B_TT0 = 0;
  localparam int TLIC_B_EF0 = 1;
  localparam int TLIC_B_TT1 = 2;
  localparam int TLIC_B_EF1 = 3;
  localparam int TLIC_B_TF0 = 5;
  localparam int TLIC_B_TF1 = 7;
  localparam int TLIC_B_EF2 = 4;
  localparam int TLIC_B_HC2 = 4;
  localparam int TLIC_B_WATCHDOG_TIMEOUT_FLAG = 3;
  localparam int TLIC_B_GLOBAL = 7;
  localparam int TLIC_B_RX = 0;
  localparam int TLIC_B_TX = 1;
  localparam int TLIC_B_T2CAP = 6;
  localparam int TLIC_B_T2OVF = 7;
  localparam int TLIC_B_ISR_LO = 0;
  localparam int TLIC_B_ISR_HI = 1;
  localparam int TLIC_B_BUSY = 2;
  localparam int TLIC_B_SRC = 4;
  localparam logic [7:0] TLIC_RST_BYTE = 8'h00;
  // flag indices
  localparam int TLIC_F_EXT0 = 0;
  localparam int TLIC_F_TMR0 = 1;
  localparam int TLIC_F_EXT1 = 2;
  localparam int TLIC_F_TMR1 = 3;
  localparam int TLIC_F_S0RX = 4;
  localparam int TLIC_F_S0TX = 5;
  localparam int TLIC_F_T2OV = 6;
  localparam int TLIC_F_T2CP = 7;
  localparam int TLIC_F_S1RX = 8;
  localparam int TLIC_F_S1TX = 9;
  localparam int TLIC_F_EXT2 = 10;
  localparam int TLIC_F_WDOG = 14;
  // source indices, fixed order highest first
  localparam logic [3:0] TLIC_S_EXT0 = 4'h0;
  localparam logic [3:0] TLIC_S_TMR0 = 4'h1;
  localparam logic [3:0] TLIC_S_EXT1 = 4'h2;
  localparam logic [3:0] TLIC_S_TMR1 = 4'h3;
  localparam logic [3:0] TLIC_S_SER0 = 4'h4;
  localparam logic [3:0] TLIC_S_TMR2 = 4'h5;
  localparam logic [3:0] TLIC_S_SER1 = 4'h6;
  localparam logic [3:0] TLIC_S_EXT2 = 4'h7;
  localparam logic [15:0] TLIC_VEC [TLIC_NSRC] = '{16'h0003, 16'h000B, 16'h0013,
    16'h001B, 16'h0023, 16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053,
    16'h005B, 16'h0063};
  typedef enum logic [1:0] {TLIC_ST_IDLE = 2'b01, TLIC_ST_CALL = 2'b10} tlic_state_e;
endpackage

/* File: rtl/tlic_top.sv */
// two-level interrupt controller: flags, enables, priority, vector call
// assumes the core reports last cycle, blocking instructions and returns
//
// What this block does
// - pins 0 and 1 pick edge or level by trigger bit; flags in timer control
// - edge mode: sample once per machine cycle, high then low sets flag
// - vectoring to pin 0 or 1 clears its flag only in edge mode
// - level pin still low after handler gives another request
// - pins 2 to 5 falling edge only, flags in extended flag register
// - pins 2 to 5 flags cleared by software, or on entry when selected
// - timer 0 and 1 overflow flags request, cleared on vectoring
// - timer 2 requests on overflow or capture; software clears both
// - watchdog timeout flag bit 3 requests when extended enable bit 4 set
// - serial port requests on rx or tx done; only software clears
// - every flag software writable, so software can raise an interrupt
// - per-source enable plus a global enable blocking all
// - per-source high or low level; low never preempts high handler
// - equal-level ties resolve ext0 first down to watchdog last
// - every machine cycle flags sampled, polled and prioritised
// - call only if no equal/higher handler, last cycle, no blocking instruction
// - requests are not remembered between polls
// - hardware call pushes program counter only, not status word
// - call loads the fixed vector of the chosen source
// - only return-from-interrupt ends the current level's handler
// - vector call lasts four machine cycles
//
// Local design decisions: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
module tlic_top #(
  parameter int CLK_PER_MC = tlic_pkg::TLIC_CLK_PER_MC,
  parameter int CALL_MC = tlic_pkg::TLIC_CALL_MC
) (
  input wire logic MCLK_I,
  input wire logic SYS_RST_I,
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic [5:0] EXT_IRQ_PIN_I,
  input wire logic TIMER0_OVF_I,
  input wire logic TIMER1_OVF_I,
  input wire logic TIMER2_OVF_I,
  input wire logic TIMER2_CAP_I,
  input wire logic SER0_RX_DONE_I,
  input wire logic SER0_TX_DONE_I,
  input wire logic SER1_RX_DONE_I,
  input wire logic SER1_TX_DONE_I,
  input wire logic WDT_TIMEOUT_I,
  input wire logic CORE_LAST_CYCLE_I,
  input wire logic CORE_BLOCK_INSTR_I,
  input wire logic CORE_RETURN_FROM_INTERRUPT_I,
  output logic MC_TICK_O,
  output logic CALL_REQ_O,
  output logic CALL_BUSY_O,
  output logic [15:0] VECTOR_O
);
  localparam int MCW = $clog2(CLK_PER_MC);
  localparam int NF = tlic_pkg::TLIC_NFLAG;
  localparam int NS = tlic_pkg::TLIC_NSRC;
  localparam int CALL_END = CLK_PER_MC * CALL_MC + 1;

  logic [MCW-1:0] mc_cnt_reg;
  logic mc_tick;
  logic [5:0] pin_smp_reg;
  logic [5:0] edge_det;
  logic [1:0] tt_reg;
  logic [3:0] hc_reg;
  logic [7:0] ien_reg;
  logic [4:0] een_reg;
  logic [6:0] prio_reg;
  logic [4:0] eprio_reg;
  logic [NF-1:0] flag_reg;
  logic [NF-1:0] hw_set;
  logic [NF-1:0] hw_clr;
  logic [NF-1:0] sw_wr;
  logic [NF-1:0] sw_val;
  logic [NS-1:0] src_flag;
  logic [NS-1:0] req;
  logic [NS-1:0] hi_req;
  logic [NS-1:0] lo_req;
  logic pick_hi;
  logic pick_lo;
  logic issue;
  logic [3:0] sel;
  logic isr_lo_reg;
  logic isr_hi_reg;
  tlic_pkg::tlic_state_e state_reg;
  logic [2:0] mc_left_reg;
  logic [3:0] src_reg;
  logic [15:0] vec_reg;
  logic call_req_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [7:0] rd_mux;
  logic wr_en;
  logic [7:0] wd;

  function automatic logic [3:0] first_set(input logic [NS-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NS - 1; i >= 0; i--)
    begin
      if (v[i])
        idx = 4'(i);
    end
    return idx;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // machine cycle timing
  // one poll per machine cycle
  assign mc_tick = (mc_cnt_reg == MCW'(CLK_PER_MC - 1));
  assign MC_TICK_O = mc_tick;

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I || mc_tick)
      mc_cnt_reg <= '0;
    else
      mc_cnt_reg <= mc_cnt_reg + 1'b1;
  end

  // pin sample once per machine cycle
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      pin_smp_reg <= 6'h3F;
    else if (mc_tick)
      pin_smp_reg <= EXT_IRQ_PIN_I;
  end
  // pins need a full machine cycle per level, else an edge can be missed
  assign edge_det = pin_smp_reg & ~EXT_IRQ_PIN_I;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle on every access
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  assign AVS_READDATA_O = rdata_reg;
  assign wr_en = AVS_WRITE_I && ack_reg && AVS_BYTEENABLE_I[0];
  assign wd = AVS_WRITEDATA_I[7:0];

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      ack_reg <= 1'b0;
    else
      ack_reg <= (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
      rdata_reg <= 32'h0000_0000;
    else if (AVS_READ_I && !ack_reg)
      rdata_reg <= {24'h00_0000, rd_mux};
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      tt_reg <= 2'h0;
      hc_reg <= 4'h0;
      ien_reg <= tlic_pkg::TLIC_RST_BYTE;
      een_reg <= 5'h00;
      prio_reg <= 7'h00;
      eprio_reg <= 5'h00;
    end
    else if (wr_en)
    begin
      unique case (AVS_ADDRESS_I)
        tlic_pkg::TLIC_OFS_TIMER_CTRL:
          tt_reg <= {wd[tlic_pkg::TLIC_B_TT1], wd[tlic_pkg::TLIC_B_TT0]};
        tlic_pkg::TLIC_OFS_T2_MODE:
          hc_reg <= wd[tlic_pkg::TLIC_B_HC2 +: 4];
        tlic_pkg::TLIC_OFS_IRQ_EN:
          ien_reg <= wd;
        tlic_pkg::TLIC_OFS_EXT_EN:
          een_reg <= wd[4:0];
        tlic_pkg::TLIC_OFS_PRIO:
          prio_reg <= wd[6:0];
        tlic_pkg::TLIC_OFS_EXT_PRIO:
          eprio_reg <= wd[4:0];
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    rd_mux = 8'h00;
    unique case (AVS_ADDRESS_I)
      tlic_pkg::TLIC_OFS_TIMER_CTRL:
      begin
        rd_mux[tlic_pkg::TLIC_B_TT0] = tt_reg[0];
        rd_mux[tlic_pkg::TLIC_B_EF0] = flag_reg[tlic_pkg::TLIC_F_EXT0];
        rd_mux[tlic_pkg::TLIC_B_TT1] = tt_reg[1];
        rd_mux[tlic_pkg::TLIC_B_EF1] = flag_reg[tlic_pkg::TLIC_F_EXT1];
        rd_mux[tlic_pkg::TLIC_B_TF0] = flag_reg[tlic_pkg::TLIC_F_TMR0];
        rd_mux[tlic_pkg::TLIC_B_TF1] = flag_reg[tlic_pkg::TLIC_F_TMR1];
      end
      tlic_pkg::TLIC_OFS_EXT_FLAG:
        rd_mux[tlic_pkg::TLIC_B_EF2 +: 4] = flag_reg[tlic_pkg::TLIC_F_EXT2 +: 4];
      tlic_pkg::TLIC_OFS_T2_MODE:
        rd_mux[tlic_pkg::TLIC_B_HC2 +: 4] = hc_reg;
      tlic_pkg::TLIC_OFS_WDOG_CTRL:
        rd_mux[tlic_pkg::TLIC_B_WATCHDOG_TIMEOUT_FLAG] = flag_reg[tlic_pkg::TLIC_F_WDOG];
      tlic_pkg::TLIC_OFS_IRQ_EN:
        rd_mux = ien_reg;
      tlic_pkg::TLIC_OFS_EXT_EN:
        rd_mux[4:0] = een_reg;
      tlic_pkg::TLIC_OFS_PRIO:
        rd_mux[6:0] = prio_reg;
      tlic_pkg::TLIC_OFS_EXT_PRIO:
        rd_mux[4:0] = eprio_reg;
      tlic_pkg::TLIC_OFS_SER0_CTRL:
      begin
        rd_mux[tlic_pkg::TLIC_B_RX] = flag_reg[tlic_pkg::TLIC_F_S0RX];
        rd_mux[tlic_pkg::TLIC_B_TX] = flag_reg[tlic_pkg::TLIC_F_S0TX];
      end
      tlic_pkg::TLIC_OFS_SER1_CTRL:
      begin
        rd_mux[tlic_pkg::TLIC_B_RX] = flag_reg[tlic_pkg::TLIC_F_S1RX];
        rd_mux[tlic_pkg::TLIC_B_TX] = flag_reg[tlic_pkg::TLIC_F_S1TX];
      end
      tlic_pkg::TLIC_OFS_T2_FLAGS:
      begin
        rd_mux[tlic_pkg::TLIC_B_T2CAP] = flag_reg[tlic_pkg::TLIC_F_T2CP];
        rd_mux[tlic_pkg::TLIC_B_T2OVF] = flag_reg[tlic_pkg::TLIC_F_T2OV];
      end
      tlic_pkg::TLIC_OFS_STATUS:
      begin
        rd_mux[tlic_pkg::TLIC_B_ISR_LO] = isr_lo_reg;
        rd_mux[tlic_pkg::TLIC_B_ISR_HI] = isr_hi_reg;
        rd_mux[tlic_pkg::TLIC_B_BUSY] = CALL_BUSY_O;
        rd_mux[tlic_pkg::TLIC_B_SRC +: 4] = src_reg;
      end
      default:
        rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // request flags
  // software writes reach every flag
  always_comb
  begin
    sw_wr = '0;
    sw_val = '0;
    sw_val[tlic_pkg::TLIC_F_EXT0] = wd[tlic_pkg::TLIC_B_EF0];
    sw_val[tlic_pkg::TLIC_F_EXT1] = wd[tlic_pkg::TLIC_B_EF1];
    sw_val[tlic_pkg::TLIC_F_TMR0] = wd[tlic_pkg::TLIC_B_TF0];
    sw_val[tlic_pkg::TLIC_F_TMR1] = wd[tlic_pkg::TLIC_B_TF1];
    sw_val[tlic_pkg::TLIC_F_EXT2 +: 4] = wd[tlic_pkg::TLIC_B_EF2 +: 4];
    sw_val[tlic_pkg::TLIC_F_WDOG] = wd[tlic_pkg::TLIC_B_WATCHDOG_TIMEOUT_FLAG];
    sw_val[tlic_pkg::TLIC_F_S0RX] = wd[tlic_pkg::TLIC_B_RX];
    sw_val[tlic_pkg::TLIC_F_S0TX] = wd[tlic_pkg::TLIC_B_TX];
    sw_val[tlic_pkg::TLIC_F_S1RX] = wd[tlic_pkg::TLIC_B_RX];
    sw_val[tlic_pkg::TLIC_F_S1TX] = wd[tlic_pkg::TLIC_B_TX];
    sw_val[tlic_pkg::TLIC_F_T2OV] = wd[tlic_pkg::TLIC_B_T2OVF];
    sw_val[tlic_pkg::TLIC_F_T2CP] = wd[tlic_pkg::TLIC_B_T2CAP];
    if (wr_en)
    begin
      unique case (AVS_ADDRESS_I)
        tlic_pkg::TLIC_OFS_TIMER_CTRL:
          sw_wr[3:0] = 4'hF;
        tlic_pkg::TLIC_OFS_EXT_FLAG:
          sw_wr[tlic_pkg::TLIC_F_EXT2 +: 4] = 4'hF;
        tlic_pkg::TLIC_OFS_WDOG_CTRL:
          sw_wr[tlic_pkg::TLIC_F_WDOG] = 1'b1;
        tlic_pkg::TLIC_OFS_SER0_CTRL:
          sw_wr[tlic_pkg::TLIC_F_S0TX:tlic_pkg::TLIC_F_S0RX] = 2'h3;
        tlic_pkg::TLIC_OFS_SER1_CTRL:
          sw_wr[tlic_pkg::TLIC_F_S1TX:tlic_pkg::TLIC_F_S1RX] = 2'h3;
        tlic_pkg::TLIC_OFS_T2_FLAGS:
          sw_wr[tlic_pkg::TLIC_F_T2CP:tlic_pkg::TLIC_F_T2OV] = 2'h3;
        default:
          ;
      endcase
    end
  end

  always_comb
  begin
    hw_set = '0;
    hw_clr = '0;
    // trigger bit picks edge or level
    // level flag tracks the inverted sample
    // pin still low after return asks again
    hw_set[tlic_pkg::TLIC_F_EXT0] = mc_tick && (tt_reg[0] ? edge_det[0] : !EXT_IRQ_PIN_I[0]);
    hw_set[tlic_pkg::TLIC_F_EXT1] = mc_tick && (tt_reg[1] ? edge_det[1] : !EXT_IRQ_PIN_I[1]);
    hw_clr[tlic_pkg::TLIC_F_EXT0] = mc_tick && !tt_reg[0] && EXT_IRQ_PIN_I[0];
    hw_clr[tlic_pkg::TLIC_F_EXT1] = mc_tick && !tt_reg[1] && EXT_IRQ_PIN_I[1];
    // edge-mode pin flags cleared on vectoring
    if (issue && sel == tlic_pkg::TLIC_S_EXT0 && tt_reg[0])
      hw_clr[tlic_pkg::TLIC_F_EXT0] = 1'b1;
    if (issue && sel == tlic_pkg::TLIC_S_EXT1 && tt_reg[1])
      hw_clr[tlic_pkg::TLIC_F_EXT1] = 1'b1;
    // timer 0 and 1 flags set by overflow, cleared on vectoring
    hw_set[tlic_pkg::TLIC_F_TMR0] = TIMER0_OVF_I;
    hw_set[tlic_pkg::TLIC_F_TMR1] = TIMER1_OVF_I;
    hw_clr[tlic_pkg::TLIC_F_TMR0] = issue && sel == tlic_pkg::TLIC_S_TMR0;
    hw_clr[tlic_pkg::TLIC_F_TMR1] = issue && sel == tlic_pkg::TLIC_S_TMR1;
    // pins 2 to 5 falling edge only
    for (int k = 0; k < 4; k++)
    begin
      hw_set[tlic_pkg::TLIC_F_EXT2 + k] = mc_tick && edge_det[2 + k];
      hw_clr[tlic_pkg::TLIC_F_EXT2 + k] = issue && hc_reg[k] &&
        (sel == tlic_pkg::TLIC_S_EXT2 + 4'(k));
    end
    // timer 2 flags never cleared here
    hw_set[tlic_pkg::TLIC_F_T2OV] = TIMER2_OVF_I;
    hw_set[tlic_pkg::TLIC_F_T2CP] = TIMER2_CAP_I;
    hw_set[tlic_pkg::TLIC_F_S0RX] = SER0_RX_DONE_I;
    hw_set[tlic_pkg::TLIC_F_S0TX] = SER0_TX_DONE_I;
    hw_set[tlic_pkg::TLIC_F_S1RX] = SER1_RX_DONE_I;
    hw_set[tlic_pkg::TLIC_F_S1TX] = SER1_TX_DONE_I;
    hw_set[tlic_pkg::TLIC_F_WDOG] = WDT_TIMEOUT_I;
  end

  // set beats any clear in the same cycle so no event is lost
  for (genvar i = 0; i < NF; i++)
  begin : g_flag
    always_ff @(posedge MCLK_I)
    begin
      if (SYS_RST_I)
        flag_reg[i] <= 1'b0;
      else if (hw_set[i])
        flag_reg[i] <= 1'b1;
      else if (sw_wr[i])
        flag_reg[i] <= sw_val[i];
      else if (hw_clr[i])
        flag_reg[i] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // poll and priority
  // timer 2 and serial requests are ORs of their flags
  assign src_flag = {flag_reg[tlic_pkg::TLIC_F_WDOG],
    flag_reg[tlic_pkg::TLIC_F_EXT2 +: 4],
    flag_reg[tlic_pkg::TLIC_F_S1RX] | flag_reg[tlic_pkg::TLIC_F_S1TX],
    flag_reg[tlic_pkg::TLIC_F_T2OV] | flag_reg[tlic_pkg::TLIC_F_T2CP],
    flag_reg[tlic_pkg::TLIC_F_S0RX] | flag_reg[tlic_pkg::TLIC_F_S0TX],
    flag_reg[tlic_pkg::TLIC_F_TMR1:tlic_pkg::TLIC_F_EXT0]};
  // only the present flags count, nothing is held over
  assign req = src_flag & {een_reg, ien_reg[6:0]} & {NS{ien_reg[tlic_pkg::TLIC_B_GLOBAL]}};
  assign hi_req = req & {eprio_reg, prio_reg};
  assign lo_req = req & ~{eprio_reg, prio_reg};
  assign pick_hi = (|hi_req) && !isr_hi_reg;
  assign pick_lo = (|lo_req) && !isr_hi_reg && !isr_lo_reg;
  // last cycle, no blocking instruction, no call running
  assign issue = mc_tick && CORE_LAST_CYCLE_I && !CORE_BLOCK_INSTR_I &&
    state_reg == tlic_pkg::TLIC_ST_IDLE && (pick_hi || pick_lo);
  // lowest index wins within a level
  assign sel = pick_hi ? first_set(hi_req) : first_set(lo_req);

  // set on call; cleared only by return-from-interrupt
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      isr_hi_reg <= 1'b0;
      isr_lo_reg <= 1'b0;
    end
    else if (issue)
    begin
      if (pick_hi)
        isr_hi_reg <= 1'b1;
      else
        isr_lo_reg <= 1'b1;
    end
    else if (CORE_RETURN_FROM_INTERRUPT_I)
    begin
      if (isr_hi_reg)
        isr_hi_reg <= 1'b0;
      else
        isr_lo_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector call sequencer
  // busy for four machine cycles after the call
  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      state_reg <= tlic_pkg::TLIC_ST_IDLE;
      mc_left_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        tlic_pkg::TLIC_ST_IDLE:
          if (issue)
          begin
            state_reg <= tlic_pkg::TLIC_ST_CALL;
            mc_left_reg <= 3'(CALL_MC - 1);
          end
        tlic_pkg::TLIC_ST_CALL:
          if (mc_tick)
          begin
            if (mc_left_reg == 3'h0)
              state_reg <= tlic_pkg::TLIC_ST_IDLE;
            else
              mc_left_reg <= mc_left_reg - 3'h1;
          end
      endcase
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (SYS_RST_I)
    begin
      vec_reg <= 16'h0000;
      src_reg <= 4'h0;
      call_req_reg <= 1'b0;
    end
    else
    begin
      call_req_reg <= issue;
      if (issue)
      begin
        vec_reg <= tlic_pkg::TLIC_VEC[sel];
        src_reg <= sel;
      end
    end
  end

  // core pushes the program counter only; status word is left alone
  assign CALL_REQ_O = call_req_reg;
  assign CALL_BUSY_O = (state_reg == tlic_pkg::TLIC_ST_CALL);
  assign VECTOR_O = vec_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (SYS_RST_I);

  a_edge_sets_flag: assert property (mc_tick && pin_smp_reg[3] && !EXT_IRQ_PIN_I[3]
    |=> flag_reg[tlic_pkg::TLIC_F_EXT2 + 1]) else $error("pin 3 edge lost");
  a_level_follows: assert property (mc_tick && !tt_reg[0] && !sw_wr[0]
    |=> flag_reg[0] == !$past(EXT_IRQ_PIN_I[0])) else $error("level flag wrong");
  a_edge_clear_call: assert property (issue && sel == tlic_pkg::TLIC_S_EXT0 && tt_reg[0]
    && !hw_set[0] && !sw_wr[0] |=> !flag_reg[0]) else $error("ext0 not cleared");
  a_level_kept: assert property (issue && sel == tlic_pkg::TLIC_S_EXT0 && !tt_reg[0]
    && !EXT_IRQ_PIN_I[0] |=> flag_reg[tlic_pkg::TLIC_F_EXT0]) else $error("level flag cleared");
  a_t2_kept: assert property (issue && flag_reg[tlic_pkg::TLIC_F_T2OV] && !sw_wr[6]
    |=> flag_reg[tlic_pkg::TLIC_F_T2OV]) else $error("timer 2 flag cleared");
  a_serial_kept: assert property (flag_reg[tlic_pkg::TLIC_F_S1RX] && !sw_wr[8]
    |=> flag_reg[tlic_pkg::TLIC_F_S1RX]) else $error("serial flag cleared");
  a_sw_sets_flag: assert property (sw_wr[14] && sw_val[14]
    |=> flag_reg[tlic_pkg::TLIC_F_WDOG]) else $error("software set lost");
  a_global_blocks: assert property (!ien_reg[tlic_pkg::TLIC_B_GLOBAL] |-> !issue)
    else $error("call while globally disabled");
  a_hi_not_preempt: assert property (isr_hi_reg |-> !issue) else $error("high preempted");
  a_order_fixed: assert property (issue |-> (((pick_hi ? hi_req : lo_req)
    & ((12'h001 << sel) - 12'h001)) == 12'h000)) else $error("wrong tie order");
  a_call_when: assert property (issue |-> mc_tick && CORE_LAST_CYCLE_I
    && !CORE_BLOCK_INSTR_I) else $error("call outside allowed cycle");
  a_no_latch: assert property (issue |-> req[sel]) else $error("stale request served");
  a_vector_map: assert property (issue |=> CALL_REQ_O && VECTOR_O ==
    tlic_pkg::TLIC_VEC[$past(sel)]) else $error("wrong vector");
  a_return_from_interrupt_ends: assert property (CORE_RETURN_FROM_INTERRUPT_I && isr_hi_reg && !issue |=> !isr_hi_reg)
    else $error("return did not end level");
  a_call_length: assert property (issue |=> CALL_BUSY_O [*8] ##1 CALL_BUSY_O [*8]
    ##1 !CALL_BUSY_O) else $error("call length wrong");
  a_call_end: assert property (issue |-> ##CALL_END !CALL_BUSY_O)
    else $error("call too long");
  a_isr_set: assert property (issue && !pick_hi |=> isr_lo_reg) else $error("level lost");

  c_ext0_call: cover property (issue && sel == tlic_pkg::TLIC_S_EXT0);
  c_nested: cover property (isr_lo_reg && issue && pick_hi);
  c_wdog_call: cover property (issue && sel == 4'hB);
  c_return_from_interrupt: cover property (CORE_RETURN_FROM_INTERRUPT_I && isr_lo_reg && !isr_hi_reg);
endmodule

/* File: testbench/tlic_core_model.sv */
// core sequencer model: instruction ends, blocking work, returns
// assumes the controller's machine-cycle tick on the same clock
`timescale 1ns/1ns
module tlic_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic block_i,
  input wire logic return_from_interrupt_req_i,
  output logic last_o,
  output logic block_o,
  output logic return_from_interrupt_o
);
  logic [1:0] cnt_reg;
  logic [1:0] len_reg;
  logic pend_reg;
  // instructions of 1 to 4 machine cycles
  assign last_o = (cnt_reg == len_reg);
  assign block_o = block_i | pend_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_reg <= 2'h0;
      len_reg <= 2'h0;
      pend_reg <= 1'b0;
      return_from_interrupt_o <= 1'b0;
    end
    else
    begin
      return_from_interrupt_o <= 1'b0;
      if (tick_i && last_o)
      begin
        cnt_reg <= 2'h0;
        len_reg <= len_reg + 2'h1;
        return_from_interrupt_o <= pend_reg;
        pend_reg <= 1'b0;
      end
      else if (tick_i)
        cnt_reg <= cnt_reg + 2'h1;
      // placed last so a request in the closing cycle is not lost
      if (return_from_interrupt_req_i)
        pend_reg <= 1'b1;
    end
  end
endmodule

/* File: testbench/two_level_interrupt_controller_tb_top.sv */
// random and corner tests of the interrupt controller
// assumes rtl/tlic_top.sv and the core model
`timescale 1ns/1ns
module two_level_interrupt_controller_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [5:0] pin = 6'h3F;
  logic [8:0] hw = 9'h000;
  logic blk = 1'b0;
  logic rreq = 1'b0;
  logic [31:0] rdata;
  logic wreq, tick, last, block, return_from_interrupt, call, busy;
  logic [15:0] vec;
  logic [7:0] q;
  logic hi;
  logic [3:0] hc;
  logic [7:0] e;
  int n;
  int m;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int a;
  logic [15:0] vec_tab [12] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023,
    16'h002B, 16'h003B, 16'h0043, 16'h004B, 16'h0053, 16'h005B, 16'h0063};
  logic [5:0] ofs_tab [12] = '{6'h00, 6'h00, 6'h00, 6'h00, 6'h20, 6'h28, 6'h24,
    6'h04, 6'h04, 6'h04, 6'h04, 6'h0C};
  logic [7:0] bit_tab [12] = '{8'h02, 8'h20, 8'h08, 8'h80, 8'h01, 8'h80, 8'h01,
    8'h10, 8'h20, 8'h40, 8'h80, 8'h08};
  logic [8:0] hw_tab [12] = '{9'h000, 9'h001, 9'h000, 9'h002, 9'h010, 9'h004,
    9'h040, 9'h000, 9'h000, 9'h000, 9'h000, 9'h100};
  logic [5:0] clr_tab [6] = '{6'h00, 6'h04, 6'h0C, 6'h20, 6'h24, 6'h28};
  always #50 clk = ~clk;
  tlic_top tlic_top_i (.MCLK_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I({24'h000000, wd}),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
    .EXT_IRQ_PIN_I(pin), .TIMER0_OVF_I(hw[0]), .TIMER1_OVF_I(hw[1]),
    .TIMER2_OVF_I(hw[2]), .TIMER2_CAP_I(hw[3]), .SER0_RX_DONE_I(hw[4]),
    .SER0_TX_DONE_I(hw[5]), .SER1_RX_DONE_I(hw[6]), .SER1_TX_DONE_I(hw[7]),
    .WDT_TIMEOUT_I(hw[8]), .CORE_LAST_CYCLE_I(last), .CORE_BLOCK_INSTR_I(block),
    .CORE_RETURN_FROM_INTERRUPT_I(return_from_interrupt), .MC_TICK_O(tick), .CALL_REQ_O(call), .CALL_BUSY_O(busy),
    .VECTOR_O(vec));
  tlic_core_model tlic_core_model_i (.clk_i(clk), .rst_i(rst), .tick_i(tick),
    .block_i(blk), .return_from_interrupt_req_i(rreq), .last_o(last), .block_o(block), .return_from_interrupt_o(return_from_interrupt));
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (bad_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one Avalon cycle; data taken only at the edge with waitrequest low
  task bus(input logic w, input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk);
    adr <= ad;
    wr <= w;
    rd <= !w;
    wd <= d;
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rchk(input string n, input logic [5:0] ad, input logic [7:0] e);
    bus(1'b0, ad, 8'h00);
    chk(n, {8'h00, q}, {8'h00, e});
  endtask
  task wait_call;
    while (call !== 1'b1) @(negedge clk);
  endtask
  task wait_idle;
    while (busy !== 1'b0) @(negedge clk);
  endtask
  task do_return_from_interrupt;
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    while (return_from_interrupt !== 1'b1) @(negedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard: well above 20 trials of roughly a hundred clocks
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      bad_count++;
      finish_test;
    end
  end
  initial
  begin
    a = $urandom(32'h685B);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("status", 6'h2C, 8'h00);
    rchk("unmapped", 6'h3C, 8'h00);
    for (int t = 0; t < 20; t++)
    begin
      a = $urandom_range(11, 0);
      hi = 1'($urandom_range(1, 0));
      hc = 4'($urandom);
      bus(1'b1, 6'h10, 8'h7F);
      bus(1'b1, 6'h14, 8'h1F);
      bus(1'b1, 6'h1C, {3'h0, hi, 4'h0});
      bus(1'b1, 6'h08, {hc, 4'h0});
      bus(1'b1, 6'h00, 8'h05);
      if (hw_tab[a] != 9'h000 && $urandom_range(1, 0) == 1)
      begin
        @(posedge clk);
        hw <= hw_tab[a];
        @(posedge clk);
        hw <= 9'h000;
      end
      else
        bus(1'b1, ofs_tab[a], bit_tab[a] | (a < 4 ? 8'h05 : 8'h00));
      // watchdog ties lowest unless high level
      bus(1'b1, 6'h0C, 8'h08);
      blk <= 1'b1;
      bus(1'b1, 6'h10, 8'hFF);
      repeat (16) @(negedge clk) chk("blocked", {15'h0, call}, 16'h0000);
      @(posedge clk);
      blk <= 1'b0;
      wait_call;
      chk("vector", vec, vec_tab[hi ? 11 : a]);
      rchk("in service", 6'h2C, {hi ? 4'hB : 4'(a), 2'h1, hi, !hi});
      wait_idle;
      rchk("auto clear", 6'h00, 8'h05 | ((a < 4 && hi) ? bit_tab[a] : 8'h00));
      e = (a > 6 && a < 11 && !hi && hc[a - 7]) ? 8'h00 : bit_tab[a];
      if (a >= 4)
        rchk("kept", ofs_tab[a], e);
      foreach (clr_tab[i]) bus(1'b1, clr_tab[i], 8'h00);
      do_return_from_interrupt;
      bus(1'b0, 6'h2C, 8'h00);
      chk("released", {13'h0, q[2:0]}, 16'h0000);
    end
    bus(1'b1, 6'h00, 8'h05);
    bus(1'b1, 6'h10, 8'h81);
    // pin held low for many machine cycles
    @(posedge clk);
    pin <= 6'h36;
    wait_call;
    chk("pin vector", vec, 16'h0003);
    n = 0;
    m = 0;
    while (busy === 1'b1)
    begin
      m += int'(tick);
      @(negedge clk);
      n++;
    end
    chk("call clocks", 16'(n), 16'(tlic_pkg::TLIC_CLK_PER_MC * tlic_pkg::TLIC_CALL_MC));
    chk("call ticks", 16'(m), 16'(tlic_pkg::TLIC_CALL_MC));
    rchk("edge clear", 6'h00, 8'h05);
    rchk("pin 3 flag", 6'h04, 8'h20);
    bus(1'b1, 6'h00, 8'h00);
    do_return_from_interrupt;
    wait_call;
    chk("level again", vec, 16'h0003);
    @(posedge clk);
    pin <= 6'h3F;
    wait_idle;
    do_return_from_interrupt;
    finish_test;
  end
endmodule
